// >>> rtl/twbc_pkg.sv
`include "twbc_regs.svh"

package twbc_pkg;

  // ==========================================================
  // protocol states
  typedef enum logic [2:0] {
    TWBC_IDLE,
    TWBC_RX,
    TWBC_ACK,
    TWBC_TX,
    TWBC_TXACK,
    TWBC_WAIT
  } twbc_state_t;

  // ==========================================================
  // synchroniser of one pin: three flops and the accepted level
  typedef struct packed {
    logic [2:0] sync;
    logic level;
  } twbc_pin_t;

  // ==========================================================
  // whole state of the bus-condition engine
  typedef struct packed {
    twbc_pin_t scl;
    twbc_pin_t sda;
    twbc_state_t st;
    logic [3:0] bit_cnt;
    logic [`TWBC_WORD_BITS-1:0] shreg;
    logic first;
    logic is_read;
    logic wrote;
    logic host_ack;
    logic sda_oe;
    logic push;
    logic tx_ready;
    logic standby;
    logic busy;
    logic [`TWBC_CNT_W-1:0] busy_cnt;
  } twbc_core_t;

endpackage

// >>> rtl/twbc_regs.svh
`ifndef TWBC_REGS_SVH
`define TWBC_REGS_SVH

// ==========================================================
// timing
`define TWBC_MCLK_PERIOD_NS 5
`define TWBC_WRITE_CYCLE_TIME_US 5000
`define TWBC_WRITE_CYCLE_TIME_CYC (`TWBC_WRITE_CYCLE_TIME_US * 1000 / `TWBC_MCLK_PERIOD_NS)

// ==========================================================
// word framing
`define TWBC_WORD_BITS 8
`define TWBC_LAST_BIT 3'h7
`define TWBC_RW_BIT 0
`define TWBC_MSB 7
`define TWBC_CNT_W 24

`endif

// >>> rtl/twbc_top.sv
`include "twbc_regs.svh"

// ==========================================================
// receive buffer: registered flags, back-pressure on in_ready
module twbc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // filling side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // draining side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // whole state of the buffer; the storage array sits beside it
  typedef struct packed {
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic valid;
    logic [WIDTH-1:0] head;
  } twbc_fifo_st_t;

  twbc_fifo_st_t s;
  twbc_fifo_st_t next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_push;
  logic do_pop;

  // ready is true only while a slot is really free
  assign o_in_ready = (s.count != CW'(DEPTH));
  // both outputs leave flops, so the head word is fetched ahead
  assign o_out_valid = s.valid;
  assign o_out_data = s.head;
  assign do_push = i_in_valid && o_in_ready;
  assign do_pop = s.valid && i_out_ready;

  // pointer wrap written out so depth need not be a power of two
  function automatic logic [PW-1:0] twbc_inc(input logic [PW-1:0] p);
    twbc_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  // pointers, occupancy and head word; a word written into the head
  // slot in this cycle is passed on directly, the array is too late
  always_comb begin
    next_s = s;
    if (do_push) next_s.wr_ptr = twbc_inc(s.wr_ptr);
    if (do_pop) next_s.rd_ptr = twbc_inc(s.rd_ptr);
    if (do_push && !do_pop) next_s.count = s.count + CW'(1);
    else if (do_pop && !do_push) next_s.count = s.count - CW'(1);
    next_s.valid = (next_s.count != '0);
    if (do_push && next_s.rd_ptr == s.wr_ptr) next_s.head = i_in_data;
    else next_s.head = mem[next_s.rd_ptr];
  end

  // single state register of the buffer
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge i_mclk) begin
    if (do_push) mem[s.wr_ptr] <= i_in_data;
  end
endmodule

// ==========================================================
// slave end of the two-wire bus, sequenced by the host's clock
module twbc_top
  import twbc_pkg::*;
#(
  parameter int WRITE_CYCLES = `TWBC_WRITE_CYCLE_TIME_CYC,
  parameter int FIFO_DEPTH = 4
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // received words
  output logic o_rx_valid,
  output logic [`TWBC_WORD_BITS-1:0] o_rx_data,
  input wire logic i_rx_ready,
  // words to send
  input wire logic i_tx_valid,
  input wire logic [`TWBC_WORD_BITS-1:0] i_tx_data,
  output logic o_tx_ready,
  // status
  output logic o_standby,
  output logic o_busy
);
  twbc_core_t r;
  twbc_core_t next_r;
  logic fifo_ready;
  logic scl_rise;
  logic scl_fall;
  logic sda_chg;
  logic start_seen;
  logic stop_seen;

  // a level counts once the second and third stages agree
  function automatic logic twbc_changed(input twbc_pin_t p);
    twbc_changed = (p.sync[1] == p.sync[2]) && (p.sync[2] != p.level);
  endfunction

  // edge and condition decode from the accepted levels
  always_comb begin
    scl_rise = twbc_changed(r.scl) && r.scl.sync[2];
    scl_fall = twbc_changed(r.scl) && !r.scl.sync[2];
    sda_chg = twbc_changed(r.sda);
    // data moving while clock is high and steady is never data
    start_seen = sda_chg && r.scl.level && !twbc_changed(r.scl) && !r.sda.sync[2];
    stop_seen = sda_chg && r.scl.level && !twbc_changed(r.scl) && r.sda.sync[2];
  end

  // next-state of the whole engine
  always_comb begin
    next_r = r;
    next_r.scl.sync = {r.scl.sync[1:0], i_scl};
    next_r.sda.sync = {r.sda.sync[1:0], i_sda};
    if (twbc_changed(r.scl)) next_r.scl.level = r.scl.sync[2];
    if (sda_chg) next_r.sda.level = r.sda.sync[2];
    next_r.push = 1'b0;
    next_r.tx_ready = 1'b0;

    // self-timed write runs off the system clock, not the bus
    if (r.busy) begin
      if (r.busy_cnt == '0) next_r.busy = 1'b0;
      else next_r.busy_cnt = r.busy_cnt - `TWBC_CNT_W'(1);
    end

    if (r.busy) begin
      // the bus is ignored while the array is written
      next_r.st = TWBC_IDLE;
      next_r.sda_oe = 1'b0;
    end else if (start_seen) begin
      // a start resets any half-done transfer
      next_r.st = TWBC_RX;
      next_r.bit_cnt = '0;
      next_r.first = 1'b1;
      next_r.is_read = 1'b0;
      next_r.wrote = 1'b0;
      next_r.standby = 1'b0;
      next_r.sda_oe = 1'b0;
    end else if (stop_seen) begin
      next_r.st = TWBC_IDLE;
      next_r.sda_oe = 1'b0;
      // the kind of transaction is spent, so a stray stop does nothing
      next_r.is_read = 1'b0;
      next_r.wrote = 1'b0;
      if (r.is_read) begin
        next_r.standby = 1'b1;
      end else if (r.wrote) begin
        next_r.busy = 1'b1;
        next_r.busy_cnt = `TWBC_CNT_W'(WRITE_CYCLES - 1);
      end
    end else begin
      case (r.st)
        TWBC_RX: begin
          if (scl_rise && r.bit_cnt != 4'(`TWBC_WORD_BITS)) begin
            next_r.shreg = {r.shreg[`TWBC_MSB-1:0], r.sda.level};
            next_r.bit_cnt = r.bit_cnt + 4'h1;
          end else if (scl_fall && r.bit_cnt == 4'(`TWBC_WORD_BITS)) begin
            // a full buffer leaves the ninth clock unanswered
            if (fifo_ready) begin
              next_r.push = 1'b1;
              next_r.sda_oe = 1'b1;
              next_r.st = TWBC_ACK;
              next_r.first = 1'b0;
              if (r.first) next_r.is_read = r.shreg[`TWBC_RW_BIT];
              else next_r.wrote = 1'b1;
            end else begin
              next_r.st = TWBC_WAIT;
            end
          end
        end
        TWBC_ACK: begin
          // release at the falling edge that ends the ninth clock
          if (scl_fall) begin
            next_r.sda_oe = 1'b0;
            next_r.bit_cnt = '0;
            next_r.st = TWBC_RX;
            if (r.is_read) begin
              if (i_tx_valid) begin
                next_r.shreg = i_tx_data;
                next_r.tx_ready = 1'b1;
                next_r.sda_oe = !i_tx_data[`TWBC_MSB];
                next_r.st = TWBC_TX;
              end else begin
                next_r.st = TWBC_WAIT;
              end
            end
          end
        end
        TWBC_TX: begin
          // outgoing bits change only on the falling edge
          if (scl_fall) begin
            if (r.bit_cnt[2:0] == `TWBC_LAST_BIT) begin
              next_r.sda_oe = 1'b0;
              next_r.st = TWBC_TXACK;
            end else begin
              next_r.shreg = {r.shreg[`TWBC_MSB-1:0], 1'b0};
              next_r.sda_oe = !r.shreg[`TWBC_MSB-1];
              next_r.bit_cnt = r.bit_cnt + 4'h1;
            end
          end
        end
        TWBC_TXACK: begin
          if (scl_rise) next_r.host_ack = !r.sda.level;
          if (scl_fall) begin
            next_r.bit_cnt = '0;
            if (r.host_ack && i_tx_valid) begin
              next_r.shreg = i_tx_data;
              next_r.tx_ready = 1'b1;
              next_r.sda_oe = !i_tx_data[`TWBC_MSB];
              next_r.st = TWBC_TX;
            end else begin
              next_r.st = TWBC_WAIT;
            end
          end
        end
        TWBC_IDLE, TWBC_WAIT: begin
          next_r.sda_oe = 1'b0;
        end
        default: begin
          next_r.st = TWBC_IDLE;
          next_r.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // single state register; pins reset to the idle-high bus
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r <= '0;
      r.scl <= '1;
      r.sda <= '1;
      r.st <= TWBC_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // receive buffer between bus and user
  twbc_fifo #(
    .WIDTH(`TWBC_WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_in_valid(r.push),
    .i_in_data(r.shreg),
    .o_in_ready(fifo_ready),
    .o_out_valid(o_rx_valid),
    .o_out_data(o_rx_data),
    .i_out_ready(i_rx_ready)
  );

  // pin only ever pulls low; the pull-up gives the high level
  assign o_sda_out = 1'b0;
  assign o_sda_oe = r.sda_oe;
  assign o_tx_ready = r.tx_ready;
  assign o_standby = r.standby;
  assign o_busy = r.busy;
endmodule

// >>> verif/twbc_checker.sv
// ==========================================================
// protocol watcher on the slave's pins
module twbc_checker #(
  parameter int WRITE_CYCLES = 400
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic o_rx_valid,
  input wire logic i_rx_ready,
  input wire logic o_tx_ready,
  input wire logic o_standby,
  input wire logic o_busy
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  logic [31:0] busy_cyc;
  // length of the current write cycle, so that its end can be judged
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) busy_cyc <= 32'h0;
    else busy_cyc <= o_busy ? busy_cyc + 32'h1 : 32'h0;
  end
  sequence s_oe_held;
    o_sda_oe [*4];
  endsequence
  a_drain_only_low: assert property (o_sda_out == 1'b0)
    else $error("data pin driven high");
  a_drive_clk_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data drive changed while clock high");
  a_drive_holds: assert property ($rose(o_sda_oe) |-> s_oe_held)
    else $error("low drive dropped too soon");
  a_busy_length: assert property ($fell(o_busy) |->
    busy_cyc == WRITE_CYCLES)
    else $error("write cycle length wrong");
  a_busy_quiet: assert property (o_busy |-> !o_sda_oe && !o_tx_ready)
    else $error("bus answered during write cycle");
  a_standby_at_stop: assert property ($rose(o_standby) |-> i_scl && i_sda)
    else $error("standby entered without stop");
  a_standby_end: assert property ($fell(o_standby) |-> i_scl && !i_sda)
    else $error("standby left without start");
  a_ready_one_pulse: assert property (o_tx_ready |=> !o_tx_ready)
    else $error("send word taken twice");
  a_rx_word_held: assert property (o_rx_valid && !i_rx_ready |=> o_rx_valid)
    else $error("received word lost");
endmodule
bind twbc_top twbc_checker #(.WRITE_CYCLES(WRITE_CYCLES)) i_twbc_checker (
  .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_rx_valid(o_rx_valid),
  .i_rx_ready(i_rx_ready), .o_tx_ready(o_tx_ready), .o_standby(o_standby),
  .o_busy(o_busy));

// >>> verif/twbc_host.sv
// ==========================================================
// host master: drives the clock, pulls data low or lets it float
module twbc_host (
  // bus
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_lo
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_scl = 1'b1;
    o_sda_lo = 1'b0;
  end
  // one clock; data set 8 ns into the low phase, line sampled mid-high
  task automatic clk_bit(input logic b, output logic r);
    o_sda_lo = !b;
    #24 o_scl = 1'b1;
    #16 r = i_sda;
    #16 o_scl = 1'b0;
    #8;
  endtask
  task automatic start();
    o_sda_lo = 1'b0;
    o_scl = 1'b1;
    #32 o_sda_lo = 1'b1;
    #32 o_scl = 1'b0;
    #8;
  endtask
  task automatic stop();
    o_sda_lo = 1'b1;
    #24 o_scl = 1'b1;
    #32 o_sda_lo = 1'b0;
    #32;
  endtask
  // msb first, then a released ninth clock for the answer
  task automatic byte_wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, r);
    ack = !r;
  endtask
  task automatic byte_rd(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(nack, r); // host answer on the ninth clock
  endtask
  // clock until the line floats high, at most nine times
  task automatic recover();
    logic r;
    for (int i = 0; i < 9; i++) begin
      clk_bit(1'b1, r);
      if (r) break;
    end
    start();
  endtask
endmodule

// >>> verif/twbc_tb_top.sv
module twbc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WC = 400;
  logic mclk = 1'b0, rst_b = 1'b0, scl, sda_lo, sda, sda_out, sda_oe;
  logic rx_valid, rx_ready = 1'b0, tx_valid = 1'b0, tx_ready, standby, busy;
  logic [7:0] rx_data, tx_data = 8'hc3;
  int n_fail = 0, tests_run = 0;
  int n_tx = 0;
  // ==========================================================
  // clock, pull-up wire, design and host
  always #2.5 mclk = ~mclk;
  assign sda = (sda_lo || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
  twbc_host i_twbc_host (.i_sda(sda), .o_scl(scl), .o_sda_lo(sda_lo));
  twbc_top #(.WRITE_CYCLES(WC), .FIFO_DEPTH(4)) i_twbc_top (
    .i_mclk(mclk), .i_rst_b(rst_b), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
    .o_sda_oe(sda_oe), .o_rx_valid(rx_valid), .o_rx_data(rx_data), .i_rx_ready(rx_ready),
    .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready),
    .o_standby(standby), .o_busy(busy));
  // sender side: once a word is taken, offer the inverted word next
  always @(negedge mclk) begin
    if (tx_ready === 1'b1) begin
      n_tx++;
      tx_data = ~tx_data;
    end
  end
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // bounded wait for the write-cycle flag
  task automatic wait_busy(input logic lvl, input int max);
    for (int k = 0; k < max && busy !== lvl; k++) @(negedge mclk);
    chk(busy === lvl, "write cycle flag wait ran out");
    if (busy !== lvl) wrap_up();
  endtask
  // fill the buffer until refused, poke during busy, then drain
  task automatic t_write_fill();
    logic a;
    logic [7:0] q [5] = '{8'ha0, 8'h5a, 8'h3c, 8'h11, 8'h22};
    i_twbc_host.start();
    for (int i = 0; i < 5; i++) begin
      i_twbc_host.byte_wr(q[i], a);
      chk(a === (i < 4), "write answer wrong");
    end
    i_twbc_host.stop();
    wait_busy(1'b1, 20);
    i_twbc_host.start();
    i_twbc_host.byte_wr(8'ha0, a);
    chk(a === 1'b0, "answered during write cycle");
    i_twbc_host.stop();
    wait_busy(1'b0, WC + 20);
    @(negedge mclk) rx_ready = 1'b1;
    for (int i = 0; i < 4; i++) begin
      chk(rx_valid === 1'b1 && rx_data === q[i], "received word wrong");
      @(negedge mclk);
    end
    chk(rx_valid === 1'b0, "buffer not empty");
  endtask
  // read two words, stop into standby, then recover from a torn frame
  task automatic t_read_standby();
    logic a;
    logic [7:0] d;
    tx_valid = 1'b1;
    i_twbc_host.start();
    i_twbc_host.byte_wr(8'ha1, a);
    chk(a === 1'b1, "read command not answered");
    i_twbc_host.byte_rd(1'b0, d);
    chk(d === 8'hc3, "first read word wrong");
    i_twbc_host.byte_rd(1'b1, d);
    chk(d === 8'h3c, "second read word wrong");
    i_twbc_host.stop();
    @(negedge mclk) tx_valid = 1'b0;
    chk(n_tx == 2, "send words taken wrong count");
    repeat (8) @(negedge mclk);
    chk(standby === 1'b1, "no standby after read");
    i_twbc_host.start();
    for (int i = 0; i < 3; i++) i_twbc_host.clk_bit(1'b0, a);
    i_twbc_host.recover();
    chk(standby === 1'b0, "standby kept after start");
    i_twbc_host.byte_wr(8'ha0, a);
    chk(a === 1'b1, "no answer after recovery");
    i_twbc_host.stop();
    repeat (8) @(negedge mclk);
  endtask
  // reset in the middle of a write cycle with words held must idle all
  task automatic t_reset_mid();
    logic a;
    rx_ready = 1'b0;
    i_twbc_host.start();
    i_twbc_host.byte_wr(8'ha0, a);
    i_twbc_host.byte_wr(8'h69, a);
    chk(a === 1'b1, "second write word not answered");
    i_twbc_host.stop();
    wait_busy(1'b1, 20);
    chk(rx_valid === 1'b1, "written words not held");
    @(negedge mclk) rst_b = 1'b0;
    repeat (4) @(negedge mclk);
    chk(!busy && !standby && !sda_oe && !rx_valid && !tx_ready, "outputs not idle in reset");
    rst_b = 1'b1;
    repeat (2) @(negedge mclk);
    chk(!busy && !standby && !sda_oe && !rx_valid && !tx_ready, "outputs not idle after reset");
    rx_ready = 1'b1;
    repeat (2) @(negedge mclk);
  endtask
  initial begin
    repeat (16) @(negedge mclk);
    rst_b = 1'b1;
    repeat (4) @(negedge mclk);
    t_write_fill();
    t_read_standby();
    t_reset_mid();
    wrap_up();
  end
endmodule
